// File: design/iskip_pkg.sv
// package: opcodes, widths and cycle constants for the increment-skip decoder
package iskip_pkg;
  localparam int DATA_W = 8;
  localparam int BITSEL_W = 3;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO = 8'h00;
  localparam int SKIP_CYCLES = 2;
  typedef enum logic [1:0] {
    ISKIP_NOP,
    ISKIP_INC_MEM,
    ISKIP_INC_ACC,
    ISKIP_BIT_SET
  } iskip_op_t;
endpackage

// File: design/iskip_core.sv
// increment-skip and bit-test-skip execution unit
// Behaviour
// - inc_mem_skip_zero writes byte plus one back, skips when the sum is zero
// - a taken skip inserts one dummy cycle, two cycles in total
// - nonzero increment result lets the next instruction run normally
// - inc_to_acc_skip_zero loads byte plus one into accumulator, skips on zero
// - inc_to_acc_skip_zero never writes data memory
// - accumulator variant routes the result to the accumulator only
// - bit_set_skip skips when the selected bit is one, taking two cycles
`timescale 1ns/100ps
module iskip_core
  import iskip_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issueValid,
  input wire iskip_pkg::iskip_op_t issueOp,
  input wire logic [iskip_pkg::BITSEL_W-1:0] bitSel,
  input wire logic [iskip_pkg::DATA_W-1:0] memRdata,
  output logic issueReady,
  output logic memWe,
  output logic [iskip_pkg::DATA_W-1:0] memWdata,
  output logic [iskip_pkg::DATA_W-1:0] accumulator_reg,
  output logic skipTaken,
  output logic dummyCycle,
  output logic flagWe
);
  typedef enum logic {ISKIP_EXEC, ISKIP_DUMMY} iskip_state_t;

  iskip_state_t state_reg, state_next;
  logic [DATA_W-1:0] acc_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic we_reg, we_next;
  logic [DATA_W-1:0] sum;
  logic skipNow;
  logic accepted;

  assign sum = DATA_W'(memRdata + ONE);
  // dummy cycle stalls issue so the skipped slot is not executed
  assign issueReady = (state_reg == ISKIP_EXEC);
  assign accepted = issueValid && issueReady;
  assign dummyCycle = (state_reg == ISKIP_DUMMY);
  // flags are never touched by this unit
  assign flagWe = 1'b0;
  assign memWe = we_reg;
  assign memWdata = wdata_reg;

  always_comb begin
    skipNow = 1'b0;
    acc_next = accumulator_reg;
    we_next = 1'b0;
    wdata_next = wdata_reg;
    if (accepted) begin
      case (issueOp)
        ISKIP_INC_MEM: begin
          we_next = 1'b1;
          wdata_next = sum;
          skipNow = (sum == ZERO);
        end
        ISKIP_INC_ACC: begin
          acc_next = sum;
          skipNow = (sum == ZERO);
        end
        ISKIP_BIT_SET: begin
          skipNow = memRdata[bitSel];
        end
        default: begin
          skipNow = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    case (state_reg)
      ISKIP_EXEC: state_next = skipNow ? ISKIP_DUMMY : ISKIP_EXEC;
      ISKIP_DUMMY: state_next = ISKIP_EXEC;
      default: state_next = ISKIP_EXEC;
    endcase
  end

  assign skipTaken = skipNow;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ISKIP_EXEC;
      accumulator_reg <= ACC_RESET;
      we_reg <= 1'b0;
      wdata_reg <= ZERO;
    end else begin
      state_reg <= state_next;
      accumulator_reg <= acc_next;
      we_reg <= we_next;
      wdata_reg <= wdata_next;
    end
  end

  // skip decision seen in the issue cycle
  sequence s_skip_issue;
    skipTaken;
  endsequence

  // the skipped slot: issue stalled, nothing taken
  sequence s_dummy_slot;
    dummyCycle && !issueReady;
  endsequence

  sequence s_resume;
    !dummyCycle && issueReady;
  endsequence

  property p_skip_two;
    @(posedge clk) disable iff (!rst_n)
      s_skip_issue |=> s_dummy_slot ##1 s_resume;
  endproperty
  a_skip_dummy_cycle: assert property (p_skip_two) else $error("skip did not take two cycles");

  a_incmem_write: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_INC_MEM
    |=> memWe && memWdata == $past(sum))
    else $error("increment not written back");

  a_incmem_skip: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_INC_MEM
    |-> skipTaken == (memRdata == 8'hff))
    else $error("memory increment skip wrong");

  a_nonzero_noskip: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp != ISKIP_BIT_SET && memRdata != 8'hff
    |=> !dummyCycle)
    else $error("nonzero result skipped");

  a_incacc_value: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_INC_ACC
    |=> accumulator_reg == $past(memRdata) + 8'h01)
    else $error("accumulator not byte plus one");

  a_incacc_nowrite: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_INC_ACC
    |=> !memWe)
    else $error("accumulator variant wrote memory");

  a_acc_only_variant: assert property (@(posedge clk) disable iff (!rst_n)
    !(accepted && issueOp == ISKIP_INC_ACC)
    |=> $stable(accumulator_reg))
    else $error("accumulator changed by other op");

  a_bit_skip: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_BIT_SET
    |-> skipTaken == memRdata[bitSel])
    else $error("bit test skip wrong");

  a_flags_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !flagWe)
    else $error("flag write asserted");

  a_incacc_skip: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_INC_ACC
    |-> skipTaken == (memRdata == 8'hff))
    else $error("accumulator increment skip wrong");

  a_bitclear_noskip: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_BIT_SET && !memRdata[bitSel]
    |=> !dummyCycle)
    else $error("clear bit caused a skip");

  a_dummy_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    dummyCycle
    |=> !dummyCycle)
    else $error("dummy slot longer than one cycle");

  a_noskip_no_dummy: assert property (@(posedge clk) disable iff (!rst_n)
    !skipTaken
    |=> !dummyCycle)
    else $error("dummy slot without a skip");

  a_dummy_no_write: assert property (@(posedge clk) disable iff (!rst_n)
    dummyCycle
    |=> !memWe)
    else $error("skipped slot wrote memory");

  a_dummy_acc_hold: assert property (@(posedge clk) disable iff (!rst_n)
    dummyCycle
    |=> $stable(accumulator_reg))
    else $error("skipped slot changed accumulator");

  a_bitset_nowrite: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_BIT_SET
    |=> !memWe && $stable(accumulator_reg))
    else $error("bit test changed state");

  a_write_one_shot: assert property (@(posedge clk) disable iff (!rst_n)
    !(accepted && issueOp == ISKIP_INC_MEM)
    |=> !memWe)
    else $error("write without memory increment");

  a_wdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(accepted && issueOp == ISKIP_INC_MEM)
    |=> $stable(memWdata))
    else $error("write data changed without increment");

  a_nop_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_NOP
    |-> !skipTaken)
    else $error("idle slot skipped");

  a_incacc_noskip: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_INC_ACC && memRdata != 8'hff
    |-> !skipTaken)
    else $error("nonzero accumulator result skipped");

  a_incmem_zero_write: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_INC_MEM && memRdata == 8'hff
    |=> memWe && memWdata == ZERO)
    else $error("wrapped increment not written as zero");

  a_bitset_skip_two: assert property (@(posedge clk) disable iff (!rst_n)
    accepted && issueOp == ISKIP_BIT_SET && memRdata[bitSel]
    |=> s_dummy_slot ##1 s_resume)
    else $error("bit test skip not two cycles");

  a_ready_outside_dummy: assert property (@(posedge clk) disable iff (!rst_n)
    !dummyCycle
    |-> issueReady)
    else $error("issue stalled outside dummy slot");
endmodule

// File: test/increment_skip_instructions_tb_top.sv
// self-checking testbench for the increment-skip decoder
`timescale 1ns/100ps
module increment_skip_instructions_tb_top;
  import iskip_pkg::*;
  logic clk = 0, rst_n = 0, issueValid = 0, issueReady, memWe, skipTaken, dummyCycle, flagWe;
  logic prevSkip = 0, prevAcc = 0, es;
  iskip_op_t issueOp = ISKIP_NOP;
  logic [BITSEL_W-1:0] bitSel = 3'h0;
  logic [DATA_W-1:0] memRdata = 8'h00, memWdata, accumulator_reg, rd;
  logic [DATA_W-1:0] wq[$], aq[$];
  logic sq[$];
  int errors = 0, cmp_count = 0, cyc = 0;
  iskip_core iskip_core_i (.clk(clk), .rst_n(rst_n), .issueValid(issueValid), .issueOp(issueOp), .bitSel(bitSel),
    .memRdata(memRdata), .issueReady(issueReady), .memWe(memWe), .memWdata(memWdata),
    .accumulator_reg(accumulator_reg), .skipTaken(skipTaken), .dummyCycle(dummyCycle), .flagWe(flagWe));
  initial forever #10 clk = ~clk;
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  // an empty write queue yields an unknown note, so any unexpected write fails
  always @(posedge clk) if (rst_n) begin
    chk("flagWe", flagWe, 8'h00);
    chk("dummyCycle", dummyCycle, prevSkip);
    chk("issueReady", issueReady, !prevSkip);
    if (memWe === 1'b1) chk("memWdata", memWdata, wq.size() ? wq.pop_front() : 8'hxx);
    if (prevAcc) chk("accumulator_reg", accumulator_reg, aq.pop_front());
    prevAcc = issueValid && issueReady && issueOp == ISKIP_INC_ACC;
    es = 1'b0;
    if (issueValid && issueReady) es = sq.pop_front();
    if (issueValid && issueReady) chk("skipTaken", skipTaken, es);
    prevSkip = issueValid && issueReady && es;
  end
  initial begin
    void'($urandom(32'hb969));
    repeat (10) @(negedge clk);
    rst_n = 1;
    chk("accReset", accumulator_reg, ACC_RESET);
    $display("reset test done");
    repeat (400) begin
      @(negedge clk);
      rd = ($urandom % 3 == 0) ? 8'hff : 8'($urandom);
      issueOp = iskip_op_t'($urandom % 4);
      bitSel = 3'($urandom);
      memRdata = rd;
      issueValid = ($urandom % 4 != 0);
      // inputs held through the dummy slot so the refused request is exercised
      while (issueReady !== 1'b1) @(negedge clk);
      if (issueValid) begin
        sq.push_back(issueOp == ISKIP_BIT_SET ? rd[bitSel] : issueOp != ISKIP_NOP && rd == 8'hff);
        if (issueOp == ISKIP_INC_MEM) wq.push_back(rd + 8'h01);
        if (issueOp == ISKIP_INC_ACC) aq.push_back(rd + 8'h01);
      end
    end
    @(negedge clk);
    issueValid = 0;
    repeat (3) @(negedge clk);
    chk("pendingWrites", 8'(wq.size()), 8'h00);
    $display("random test done");
    report_and_stop();
  end
endmodule
